// [verif/asc_ctrl_asserts.sv]
`include "asc_consts.svh"
module asc_ctrl_asserts (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Memory pins.
   input wire logic [`ASC_ADDR_W-1:0] o_mem_addr,
   input wire logic o_mem_cs_b,
   input wire logic o_mem_we_b,
   input wire logic o_mem_oe_b,
   input wire logic [`ASC_DATA_W-1:0] o_mem_dq_out,
   input wire logic o_mem_dq_oe_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wgap;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // Cycles since the last strobe fall, saturating so idle time never wraps.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) wgap <= 4'hf;
      else if ($fell(o_mem_we_b)) wgap <= 4'h1;
      else if (wgap != 4'hf) wgap <= wgap + 4'h1;
   end
   chk_win_plain: assert property ($fell(o_mem_we_b) |-> (!o_mem_we_b && !o_mem_cs_b) [*4])
      else $error("write window too short");
   chk_win_oe_on: assert property ($fell(o_mem_we_b) && !o_mem_oe_b |-> !o_mem_we_b [*5])
      else $error("write window with outputs on too short");
   chk_select_low: assert property ($fell(o_mem_cs_b) |-> !o_mem_cs_b [*4])
      else $error("select pulse too short");
   chk_addr_lead: assert property ($fell(o_mem_we_b) |-> $stable(o_mem_addr))
      else $error("address moved at window open");
   chk_addr_hold: assert property (!o_mem_we_b [*2] |-> $stable(o_mem_addr))
      else $error("address moved inside window");
   chk_data_held: assert property (!o_mem_we_b |-> !o_mem_dq_oe_b && $stable(o_mem_dq_out))
      else $error("write data not held in window");
   chk_no_fight: assert property (!o_mem_cs_b && o_mem_we_b && !o_mem_oe_b |-> o_mem_dq_oe_b)
      else $error("data driven during read");
   chk_read_shape: assert property ($fell(o_mem_cs_b) && o_mem_we_b |-> (o_mem_we_b && !o_mem_oe_b) [*4])
      else $error("read cycle strobes wrong");
   chk_write_gap: assert property ($fell(o_mem_we_b) |-> wgap >= 4'h5)
      else $error("write cycles too close");
   cov_wr_plain: cover property ($fell(o_mem_we_b) && o_mem_oe_b);
   cov_wr_oe: cover property ($fell(o_mem_we_b) && !o_mem_oe_b);
   cov_read: cover property ($fell(o_mem_cs_b) && o_mem_we_b);
endmodule
bind asc_ctrl asc_ctrl_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .o_mem_addr(o_mem_addr),
   .o_mem_cs_b(o_mem_cs_b), .o_mem_we_b(o_mem_we_b), .o_mem_oe_b(o_mem_oe_b),
   .o_mem_dq_out(o_mem_dq_out), .o_mem_dq_oe_b(o_mem_dq_oe_b));

// [verif/asc_sram_model.sv]
`include "asc_consts.svh"
module asc_sram_model (
   // Control pins.
   input wire logic i_cs_b,
   input wire logic i_we_b,
   input wire logic i_oe_b,
   input wire logic [`ASC_ADDR_W-1:0] i_addr,
   // Shared data bus.
   input wire logic [`ASC_DATA_W-1:0] i_dq,
   input wire logic i_dq_oe_b,
   output logic [`ASC_DATA_W-1:0] o_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`ASC_DATA_W-1:0] mem [int];
   logic [`ASC_DATA_W-1:0] rd;
   logic [`ASC_ADDR_W-1:0] wa;
   logic [`ASC_DATA_W-1:0] wd;
   wire logic win = !i_cs_b && !i_we_b;
   always @(i_addr, o_bus, win) if (win) begin wa = i_addr; wd = o_bus; end
   // A store to the address already on the pins must show at once, since no address event follows it.
   always @(negedge win) begin
      mem[wa] = wd;
      if (wa == i_addr) rd = wd;
   end
   always @(i_addr, win) rd = mem.exists(i_addr) ? mem[i_addr] : 8'h00;
   // A floating bus shows inverted data, so a late sample cannot pass by luck.
   assign o_bus = !i_dq_oe_b ? i_dq : (!i_cs_b && i_we_b && !i_oe_b) ? rd : ~rd;
endmodule

// [verif/test_async_sram_write_read_control.sv]
`include "asc_consts.svh"
module test_async_sram_write_read_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, req, req_write, oe_wr, ready, done, rvalid, cs_b, we_b, oe_b, dq_oe_b;
   logic [`ASC_ADDR_W-1:0] addr, mem_addr;
   logic [`ASC_DATA_W-1:0] wdata, rdata, dq_out, bus;
   logic [`ASC_DATA_W-1:0] shadow [int];
   int fail_count = 0;
   int num_checks = 0;
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   asc_ctrl u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_req(req), .i_req_write(req_write), .i_req_addr(addr),
      .i_req_wdata(wdata), .i_oe_during_write(oe_wr), .o_req_ready(ready), .o_write_done(done),
      .o_rdata_valid(rvalid), .o_rdata(rdata), .o_mem_addr(mem_addr), .o_mem_cs_b(cs_b), .o_mem_we_b(we_b),
      .o_mem_oe_b(oe_b), .o_mem_dq_out(dq_out), .o_mem_dq_oe_b(dq_oe_b), .i_mem_dq_in(bus));
   asc_sram_model u_mem (.i_cs_b(cs_b), .i_we_b(we_b), .i_oe_b(oe_b), .i_addr(mem_addr), .i_dq(dq_out),
      .i_dq_oe_b(dq_oe_b), .o_bus(bus));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] expect_rd(input logic [`ASC_ADDR_W-1:0] a);
      return shadow.exists(a) ? shadow[a] : 8'h00;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic access(input logic w, input logic [`ASC_ADDR_W-1:0] a, input logic [7:0] d, input logic o);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      check({7'h00, ready}, 8'h01);
      req = 1;
      req_write = w;
      addr = a;
      wdata = d;
      oe_wr = o;
      @(posedge clk);
      #1 req = 0;
      n = 0;
      while ((w ? done : rvalid) !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      if (w) shadow[a] = d;
      if (w) check({7'h00, done}, 8'h01);
      else check(rdata, expect_rd(a));
   endtask
   initial begin
      req = 0;
      req_write = 0;
      addr = 0;
      wdata = 0;
      oe_wr = 0;
      rst_b = 0;
      void'($urandom(32'h3eca_8674));
      repeat (16) @(posedge clk);
      #1 rst_b = 1;
      check({4'h0, cs_b, we_b, oe_b, dq_oe_b}, 8'h0f);
      // Address ends, both write styles, then an unwritten byte.
      access(1, 19'h0_0000, 8'ha5, 0);
      access(1, 19'h7_ffff, 8'h5a, 1);
      access(0, 19'h7_ffff, 8'h00, 0);
      access(0, 19'h0_0000, 8'h00, 0);
      access(0, 19'h1_2345, 8'h00, 0);
      repeat (60) access(1'($urandom), 19'($urandom) & 19'h7_0007, 8'($urandom), 1'($urandom));
      complete_run();
   end
   initial begin
      #20000;
      fail_count++;
      complete_run();
   end
endmodule

// [verilog/asc_consts.svh]
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

`define ASC_CLK_PERIOD_NS 4
`define ASC_ADDR_W 19
`define ASC_DATA_W 8
`define ASC_WRITE_WINDOW_MIN_NS 14
`define ASC_WRITE_WINDOW_MIN_OUTPUTS_ON_NS 20
`define ASC_SELECT_TO_WRITE_END_NS 14
`define ASC_ADDRESS_LEAD_NS 0
`define ASC_ADDRESS_TO_WRITE_END_NS 14
`define ASC_WRITE_RECOVERY_NS 0
`define ASC_DATA_LEAD_NS 9
`define ASC_DATA_TRAIL_NS 0
`define ASC_WRITE_END_TO_DRIVE_NS 6
`define ASC_WRITE_CYCLE_MIN_NS 20
`define ASC_READ_ACCESS_NS 20
`define ASC_DESELECT_TO_FLOAT_NS 5
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_WRITE_CYC `ASC_CEIL_CYC(`ASC_WRITE_WINDOW_MIN_NS)
`define ASC_WRITE_OE_CYC `ASC_CEIL_CYC(`ASC_WRITE_WINDOW_MIN_OUTPUTS_ON_NS)
`define ASC_CYCLE_CYC `ASC_CEIL_CYC(`ASC_WRITE_CYCLE_MIN_NS)
`define ASC_READ_CYC `ASC_CEIL_CYC(`ASC_READ_ACCESS_NS)
`define ASC_TURN_CYC `ASC_CEIL_CYC(`ASC_DESELECT_TO_FLOAT_NS)
`define ASC_CNT_W 4

`endif

// [verilog/asc_ctrl.sv]
`include "asc_consts.svh"
// Summary of operation
// - Window open 14 ns, outputs off.
// - Window open 20 ns, outputs on.
// - Select low 14 ns before window closes.
// - Address valid before window opens.
// - Address valid 14 ns before close.
// - Address may change after window closes.
// - Data valid 9 ns before close.
// - Data held until window closes.
// - Never drive data while memory reads.
// - Read keeps strobe high, select/enable low.
module asc_ctrl
   import asc_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // User request port.
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [`ASC_ADDR_W-1:0] i_req_addr,
   input wire logic [`ASC_DATA_W-1:0] i_req_wdata,
   input wire logic i_oe_during_write,
   output logic o_req_ready,
   output logic o_write_done,
   output logic o_rdata_valid,
   output logic [`ASC_DATA_W-1:0] o_rdata,
   // Memory pins.
   output logic [`ASC_ADDR_W-1:0] o_mem_addr,
   output logic o_mem_cs_b,
   output logic o_mem_we_b,
   output logic o_mem_oe_b,
   output logic [`ASC_DATA_W-1:0] o_mem_dq_out,
   output logic o_mem_dq_oe_b,
   input wire logic [`ASC_DATA_W-1:0] i_mem_dq_in
);
   asc_state_e state;
   asc_state_e next_state;
   logic wr_oe;
   logic capture;
   asc_timer_if tif();

   // Phase decodes shared by the pin registers, so the pins cannot disagree.
   function automatic logic select_phase(input asc_state_e st);
      return (st == ASC_WPULSE) || (st == ASC_RACCESS);
   endfunction

   function automatic logic strobe_phase(input asc_state_e st);
      return st == ASC_WPULSE;
   endfunction

   function automatic logic drive_phase(input asc_state_e st);
      return (st == ASC_WSETUP) || (st == ASC_WPULSE) || (st == ASC_WDONE);
   endfunction

   asc_timer u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .tif(tif.timer)
   );

   asc_rdata_reg u_rdata (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_capture(capture),
      .i_bus(i_mem_dq_in),
      .o_data(o_rdata),
      .o_valid(o_rdata_valid)
   );

   // Next state and timer loads; every phase is at least one clock.
   always_comb begin
      next_state = state;
      tif.load = 1'b0;
      tif.count = 4'h0;
      capture = 1'b0;
      unique case (state)
         ASC_IDLE: begin
            if (i_req && i_req_write) begin
               // Address and data go out a clock before the window opens.
               next_state = ASC_WSETUP;
            end else if (i_req) begin
               next_state = ASC_RACCESS;
               tif.load = 1'b1;
               tif.count = 4'(`ASC_READ_CYC);
            end
         end
         ASC_WSETUP: begin
            next_state = ASC_WPULSE;
            tif.load = 1'b1;
            // With outputs enabled the window must be longer.
            tif.count = wr_oe ? 4'(`ASC_WRITE_OE_CYC) : 4'(`ASC_WRITE_CYC);
         end
         ASC_WPULSE: begin
            if (tif.expired) begin
               next_state = ASC_WDONE;
            end
         end
         ASC_WDONE: begin
            // Cycle gap so consecutive windows stay apart.
            next_state = ASC_GAP;
            tif.load = 1'b1;
            tif.count = 4'(`ASC_CYCLE_CYC);
         end
         ASC_RACCESS: begin
            if (tif.expired) begin
               capture = 1'b1;
               next_state = ASC_RTURN;
               tif.load = 1'b1;
               tif.count = 4'(`ASC_TURN_CYC);
            end
         end
         ASC_RTURN: begin
            // Wait out the memory's float time before anyone drives.
            if (tif.expired) begin
               next_state = ASC_IDLE;
            end
         end
         ASC_GAP: begin
            if (tif.expired) begin
               next_state = ASC_IDLE;
            end
         end
         default: begin
            next_state = ASC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         state <= ASC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Request capture: address and data stay put for the whole access.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_mem_addr <= 19'h0_0000;
         o_mem_dq_out <= 8'h00;
         wr_oe <= 1'b0;
      end else if (state == ASC_IDLE && i_req) begin
         o_mem_addr <= i_req_addr;
         o_mem_dq_out <= i_req_wdata;
         wr_oe <= i_req_write && i_oe_during_write;
      end
   end

   // Pin strobes. On writes, select and strobe fall and rise together, so the window
   // is bounded by both at once and the select time equals the pulse time.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_mem_cs_b <= 1'b1;
         o_mem_we_b <= 1'b1;
         o_mem_oe_b <= 1'b1;
      end else begin
         o_mem_cs_b <= !select_phase(next_state);
         o_mem_we_b <= !strobe_phase(next_state);
         o_mem_oe_b <= !(next_state == ASC_RACCESS || (strobe_phase(next_state) && wr_oe));
      end
   end

   // Data drive spans setup through one clock past the window close,
   // and is never on while a read is in progress.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_mem_dq_oe_b <= 1'b1;
      end else begin
         o_mem_dq_oe_b <= !drive_phase(next_state);
      end
   end

   // The memory may resume driving after close; the gap covers that.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_req_ready <= 1'b0;
         o_write_done <= 1'b0;
      end else begin
         o_req_ready <= (next_state == ASC_IDLE) && !(state == ASC_IDLE && i_req);
         o_write_done <= (state == ASC_WPULSE) && tif.expired;
      end
   end
endmodule

// [verilog/asc_pkg.sv]
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_WSETUP = 3'b001,
      ASC_WPULSE = 3'b010,
      ASC_WDONE = 3'b011,
      ASC_RACCESS = 3'b100,
      ASC_RTURN = 3'b101,
      ASC_GAP = 3'b110
   } asc_state_e;
   typedef logic [3:0] asc_cnt_t;
endpackage

// [verilog/asc_rdata_reg.sv]
`include "asc_consts.svh"
module asc_rdata_reg
   import asc_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Capture.
   input wire logic i_capture,
   input wire logic [`ASC_DATA_W-1:0] i_bus,
   output logic [`ASC_DATA_W-1:0] o_data,
   output logic o_valid
);
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_data <= 8'h00;
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_capture;
         if (i_capture) begin
            o_data <= i_bus;
         end
      end
   end
endmodule

// [verilog/asc_timer.sv]
`include "asc_consts.svh"
module asc_timer
   import asc_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Control.
   asc_timer_if.timer tif
);
   asc_cnt_t remain;

   // Counts down from the loaded value; expired is high when it reaches one.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         remain <= 4'h0;
      end else if (tif.load) begin
         remain <= tif.count;
      end else if (remain != 4'h0) begin
         remain <= remain - 4'h1;
      end
   end

   assign tif.expired = (remain == 4'h1) || (remain == 4'h0 && !tif.load);
endmodule

// [verilog/asc_timer_if.sv]
interface asc_timer_if;
   logic load;
   logic [3:0] count;
   logic expired;
   modport ctrl(output load, output count, input expired);
   modport timer(input load, input count, output expired);
endinterface
